// ==== alx_alu.sv ====
// Eight-bit adder/subtractor and logic unit with standard flag rules.
// Purely combinational; the core registers its results.
`timescale 1ns/1ps
`default_nettype none
module alx_alu (
    // Operands
    input  wire logic [7:0]      a,
    input  wire logic [7:0]      b,
    input  wire logic            cy_in,
    input  wire alx_pkg::alx_op_t op,
    // Results
    output logic      [7:0]      res,
    output logic                 cy,
    output logic                 ac,
    output logic                 ov
);
    logic       cin;
    logic [8:0] sum9;
    logic [4:0] sum_lo;
    logic [8:0] dif9;
    logic [4:0] dif_lo;
    logic       is_sub;

    // carry into add
    // Plain add drops the incoming carry
    assign cin    = (op == alx_pkg::OP_ADD) ? 1'b0 : cy_in;
    assign sum9   = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign sum_lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    assign dif9   = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    assign dif_lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    assign is_sub = (op == alx_pkg::OP_SUB_BR);

    // Result select; flags only meaningful for arithmetic
    assign res = (op == alx_pkg::OP_AND) ? (a & b) :
                 (op == alx_pkg::OP_OR)  ? (a | b) :
                 (op == alx_pkg::OP_XOR) ? (a ^ b) :
                 is_sub ? dif9[7:0] : sum9[7:0];
    assign cy  = is_sub ? dif9[8] : sum9[8];
    assign ac  = is_sub ? dif_lo[4] : sum_lo[4];
    assign ov  = is_sub ? ((a[7] != b[7]) && (dif9[7] != a[7]))
                        : ((a[7] == b[7]) && (sum9[7] != a[7]));
endmodule
`default_nettype wire

// ==== alx_core.sv ====
// Execution core for the arithmetic and logical instruction groups.
// Assumes code bytes arrive combinationally on code_data for code_addr, same clock.
//
// Contract
// - Standard opcodes run unchanged, same operation.
// - Indirect address comes from register zero/one.
// - Relative offset is signed, added to location.
// - Add-with-carry sums acc, carry, operand; timing.
// - Plain add ignores carry; same lengths, one cycle.
// - Subtract-with-borrow register/direct forms, one cycle.
// - Subtract immediate/indirect forms also one cycle.
// - Logic ops into acc take one cycle.
// - AND acc into direct byte writes back.
// - AND immediate into direct: three bytes, two cycles.
// - OR immediate into direct: three bytes, two cycles.
// - XOR immediate into direct: three bytes, two cycles.
`timescale 1ns/1ps
`default_nettype none
module alx_core (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Code memory
    output logic      [15:0] code_addr,
    input  wire logic [7:0]  code_data,
    // Visible state
    output logic      [7:0]  acc_value,
    output logic             carry_flag,
    output logic             aux_carry_flag,
    output logic             overflow_flag,
    output logic             instr_done
);
    alx_pkg::alx_state_t state;
    logic [7:0]  ram [0:255];
    logic [7:0]  opcode;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [3:0]  clk_cnt;
    logic [7:0]  acc_old;
    logic [2:0]  flags_old;
    logic [15:0] pc_start;
    logic [7:0]  op_a;
    logic [7:0]  op_b;
    logic [3:0]  span;

    logic [3:0]  hi;
    logic [3:0]  lo;
    logic [7:0]  ptr_addr;
    logic [7:0]  mem_addr;
    logic [7:0]  mem_val;
    logic [7:0]  alu_a;
    logic [7:0]  alu_b;
    logic        alu_cin;
    alx_pkg::alx_op_t alu_op;
    logic [7:0]  alu_res;
    logic        alu_cy;
    logic        alu_ac;
    logic        alu_ov;
    logic        exec_end;
    logic        acc_dest;
    logic        mem_dest;
    logic        flag_upd;
    logic [15:0] rel_target;

    assign hi = opcode[7:4];
    assign lo = opcode[3:0];

    assign ptr_addr = ram[{7'h00, lo[0]}];

    // Operand address: working register, pointer, or direct byte
    assign mem_addr = (lo >= alx_pkg::FORM_REG0) ? {5'h00, lo[2:0]} :
                      (lo == alx_pkg::FORM_IND0 || lo == alx_pkg::FORM_IND1) ? ptr_addr :
                      byte1;
    assign mem_val  = ram[mem_addr];

    assign acc_dest = alx_pkg::is_acc_grp(opcode) ||
                      (alx_pkg::is_incdec(opcode) && lo == alx_pkg::FORM_IMM);
    assign mem_dest = alx_pkg::is_logic_dir(opcode) ||
                      (alx_pkg::is_incdec(opcode) && lo != alx_pkg::FORM_IMM);
    assign alu_a    = (alx_pkg::is_acc_grp(opcode) || lo == alx_pkg::FORM_IMM) ? acc_old : mem_val;
    assign alu_b    = alx_pkg::is_incdec(opcode) ? 8'h01 :
                      (lo == alx_pkg::FORM_DIR_A) ? acc_old :
                      (lo == alx_pkg::FORM_DIR_IMM) ? byte2 :
                      (lo == alx_pkg::FORM_IMM) ? byte1 : mem_val;
    assign alu_cin  = alx_pkg::is_incdec(opcode) ? 1'b0 : carry_flag;
    assign alu_op   = (hi == alx_pkg::GRP_INC)  ? alx_pkg::OP_ADD :
                      (hi == alx_pkg::GRP_DEC)  ? alx_pkg::OP_SUB_BR :
                      (hi == alx_pkg::GRP_ADD)  ? alx_pkg::OP_ADD :
                      (hi == alx_pkg::GRP_ADD_CY) ? alx_pkg::OP_ADD_CY :
                      (hi == alx_pkg::GRP_SUB_BR) ? alx_pkg::OP_SUB_BR :
                      (hi == alx_pkg::GRP_AND)  ? alx_pkg::OP_AND :
                      (hi == alx_pkg::GRP_OR)   ? alx_pkg::OP_OR : alx_pkg::OP_XOR;
    assign flag_upd = alx_pkg::is_arith(opcode);
    assign rel_target = code_addr + {{8{byte1[7]}}, byte1};
    // Timing: last clock of the instruction's cycle budget
    assign exec_end = (state == alx_pkg::ST_EXEC) && (clk_cnt == alx_pkg::alx_last_clk(opcode));

    alx_alu u_alu (
        .a     (alu_a),
        .b     (alu_b),
        .cy_in (alu_cin),
        .op    (alu_op),
        .res   (alu_res),
        .cy    (alu_cy),
        .ac    (alu_ac),
        .ov    (alu_ov)
    );

    // Sequencer: fetch bytes, then wait out the instruction cycles
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state   <= alx_pkg::ST_OPCODE;
            clk_cnt <= 4'h0;
        end else begin
            clk_cnt <= exec_end ? 4'h0 : clk_cnt + 4'h1;
            case (state)
                alx_pkg::ST_OPCODE: begin
                    state <= (alx_pkg::alx_len(code_data) > 2'd1) ? alx_pkg::ST_BYTE1
                                                                  : alx_pkg::ST_EXEC;
                end
                alx_pkg::ST_BYTE1: begin
                    state <= (alx_pkg::alx_len(opcode) > 2'd2) ? alx_pkg::ST_BYTE2
                                                               : alx_pkg::ST_EXEC;
                end
                alx_pkg::ST_BYTE2: begin
                    state <= alx_pkg::ST_EXEC;
                end
                default: begin
                    if (exec_end) begin
                        state <= alx_pkg::ST_OPCODE;
                    end
                end
            endcase
        end
    end

    // Byte capture and program location
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            code_addr <= alx_pkg::PC_RESET;
            opcode    <= 8'h00;
            byte1     <= 8'h00;
            byte2     <= 8'h00;
        end else if (state == alx_pkg::ST_OPCODE) begin
            opcode    <= code_data;
            code_addr <= code_addr + 16'h0001;
        end else if (state == alx_pkg::ST_BYTE1) begin
            byte1     <= code_data;
            code_addr <= code_addr + 16'h0001;
        end else if (state == alx_pkg::ST_BYTE2) begin
            byte2     <= code_data;
            code_addr <= code_addr + 16'h0001;
        end else if (exec_end && opcode == alx_pkg::OPC_REL_JUMP) begin
            code_addr <= rel_target;
        end
    end

    // Snapshots at opcode fetch; operands frozen for the whole instruction
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_old   <= alx_pkg::ACC_RESET;
            flags_old <= 3'h0;
            pc_start  <= alx_pkg::PC_RESET;
        end else if (state == alx_pkg::ST_OPCODE) begin
            acc_old   <= acc_value;
            flags_old <= {carry_flag, aux_carry_flag, overflow_flag};
            pc_start  <= code_addr;
        end
    end

    // Accumulator and flags written on the last clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_value      <= alx_pkg::ACC_RESET;
            carry_flag     <= 1'b0;
            aux_carry_flag <= 1'b0;
            overflow_flag  <= 1'b0;
            instr_done     <= 1'b0;
            op_a           <= 8'h00;
            op_b           <= 8'h00;
        end else begin
            instr_done <= exec_end;
            if (exec_end) begin
                op_a <= alu_a;
                op_b <= alu_b;
                if (acc_dest) begin
                    acc_value <= alu_res;
                end
                if (flag_upd) begin
                    carry_flag     <= alu_cy;
                    aux_carry_flag <= alu_ac;
                    overflow_flag  <= alu_ov;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (exec_end && mem_dest) begin
            ram[mem_addr] <= alu_res;
        end
    end

    // Clocks between completions, checked below
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            span <= 4'h0;
        end else begin
            span <= instr_done ? 4'h1 : span + 4'h1;
        end
    end

    a_add_cy_sum: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && alx_pkg::is_acc_grp(opcode) && hi == alx_pkg::GRP_ADD_CY |->
        {carry_flag, acc_value} == {1'b0, acc_old} + {1'b0, op_b} + {8'h00, flags_old[2]})
        else $error("add with carry result wrong");

    a_add_no_carry: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && alx_pkg::is_acc_grp(opcode) && hi == alx_pkg::GRP_ADD |->
        {carry_flag, acc_value} == {1'b0, acc_old} + {1'b0, op_b})
        else $error("plain add used carry");

    a_sub_long: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && hi == alx_pkg::GRP_SUB_BR &&
        (lo == alx_pkg::FORM_DIR || lo >= alx_pkg::FORM_REG0)
        |-> {carry_flag, acc_value} == {1'b0, acc_old} - {1'b0, op_b} - {8'h00, flags_old[2]}
            && span == alx_pkg::CYCLE_CLKS)
        else $error("subtract register or direct wrong");

    a_sub_short: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && hi == alx_pkg::GRP_SUB_BR && lo >= alx_pkg::FORM_IMM &&
        lo < alx_pkg::FORM_REG0
        && lo != alx_pkg::FORM_DIR |-> span == alx_pkg::CYCLE_CLKS &&
        code_addr == pc_start + {14'h0000, alx_pkg::alx_len(opcode)})
        else $error("subtract immediate or indirect timing wrong");

    a_logic_acc: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && alx_pkg::is_acc_grp(opcode) && !alx_pkg::is_arith(opcode) |->
        acc_value == (hi == alx_pkg::GRP_AND ? (acc_old & op_b) :
                      hi == alx_pkg::GRP_OR ? (acc_old | op_b) : (acc_old ^ op_b))
        && span == alx_pkg::CYCLE_CLKS)
        else $error("logic into accumulator wrong");

    a_and_dir_wb: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && hi == alx_pkg::GRP_AND && lo == alx_pkg::FORM_DIR_A |->
        ram[byte1] == (op_a & acc_old) && acc_value == acc_old && span == alx_pkg::CYCLE_CLKS)
        else $error("and into direct byte wrong");

    a_dir_imm_span: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && alx_pkg::is_logic_dir(opcode) && lo == alx_pkg::FORM_DIR_IMM |->
        span == alx_pkg::CYCLE_CLKS + alx_pkg::CYCLE_CLKS && code_addr == pc_start + 16'h0003)
        else $error("immediate into direct timing wrong");

    a_logic_keep_cy: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && !alx_pkg::is_arith(opcode) |-> $stable(carry_flag) && carry_flag == flags_old[2])
        else $error("carry changed by non-arithmetic op");

    a_incdec_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && alx_pkg::is_incdec(opcode) |->
        {carry_flag, aux_carry_flag, overflow_flag} == flags_old && span == alx_pkg::CYCLE_CLKS &&
        (lo != alx_pkg::FORM_IMM || acc_value == acc_old + (hi == alx_pkg::GRP_INC ? 8'h01 : 8'hFF)))
        else $error("increment or decrement wrong");

    a_rel_jump: assert property (@(posedge ref_clk) disable iff (rst)
        instr_done && opcode == alx_pkg::OPC_REL_JUMP |->
        code_addr == $past(code_addr) + {{8{byte1[7]}}, byte1})
        else $error("relative jump target wrong");
endmodule
`default_nettype wire

// ==== alx_pkg.sv ====
// Constants, types and decode functions for the arithmetic/logic execution core.
// Assumes a single clock domain; opcodes follow the standard 8-bit controller encoding.
package alx_pkg;

    // Opcode high nibble: operation group
    localparam logic [3:0] GRP_INC  = 4'h0;
    localparam logic [3:0] GRP_DEC  = 4'h1;
    localparam logic [3:0] GRP_ADD  = 4'h2;
    localparam logic [3:0] GRP_ADD_CY = 4'h3;
    localparam logic [3:0] GRP_OR   = 4'h4;
    localparam logic [3:0] GRP_AND  = 4'h5;
    localparam logic [3:0] GRP_XOR  = 4'h6;
    localparam logic [3:0] GRP_SUB_BR = 4'h9;

    // Opcode low nibble: addressing form
    localparam logic [3:0] FORM_DIR_A   = 4'h2;
    localparam logic [3:0] FORM_DIR_IMM = 4'h3;
    localparam logic [3:0] FORM_IMM     = 4'h4;
    localparam logic [3:0] FORM_DIR     = 4'h5;
    localparam logic [3:0] FORM_IND0    = 4'h6;
    localparam logic [3:0] FORM_IND1    = 4'h7;
    localparam logic [3:0] FORM_REG0    = 4'h8;

    // Short relative jump opcode
    localparam logic [7:0] OPC_REL_JUMP = 8'h80;

    // Clocks in one instruction cycle
    localparam logic [3:0] CYCLE_CLKS = 4'h4;

    // Reset values
    localparam logic [15:0] PC_RESET  = 16'h0000;
    localparam logic [7:0]  ACC_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_OPCODE = 2'b00,
        ST_BYTE1  = 2'b01,
        ST_BYTE2  = 2'b11,
        ST_EXEC   = 2'b10
    } alx_state_t;

    typedef enum logic [2:0] {
        OP_ADD  = 3'h0,
        OP_ADD_CY = 3'h1,
        OP_SUB_BR = 3'h2,
        OP_AND  = 3'h3,
        OP_OR   = 3'h4,
        OP_XOR  = 3'h5
    } alx_op_t;

    // Group with accumulator as destination
    function automatic logic is_acc_grp(input logic [7:0] opc);
        return (opc[7:4] == GRP_ADD || opc[7:4] == GRP_ADD_CY || opc[7:4] == GRP_SUB_BR ||
                opc[7:4] == GRP_AND || opc[7:4] == GRP_OR || opc[7:4] == GRP_XOR) &&
               (opc[3:0] >= FORM_IMM);
    endfunction

    // Logical op whose destination is a direct byte
    function automatic logic is_logic_dir(input logic [7:0] opc);
        return (opc[7:4] == GRP_AND || opc[7:4] == GRP_OR || opc[7:4] == GRP_XOR) &&
               (opc[3:0] == FORM_DIR_A || opc[3:0] == FORM_DIR_IMM);
    endfunction

    function automatic logic is_incdec(input logic [7:0] opc);
        return (opc[7:4] == GRP_INC || opc[7:4] == GRP_DEC) && (opc[3:0] >= FORM_IMM);
    endfunction

    function automatic logic is_arith(input logic [7:0] opc);
        return is_acc_grp(opc) &&
               (opc[7:4] == GRP_ADD || opc[7:4] == GRP_ADD_CY || opc[7:4] == GRP_SUB_BR);
    endfunction

    // three-byte forms
    // Instruction length in bytes
    function automatic logic [1:0] alx_len(input logic [7:0] opc);
        if (is_logic_dir(opc) && opc[3:0] == FORM_DIR_IMM) begin
            return 2'd3;
        end else if (opc == OPC_REL_JUMP || is_logic_dir(opc) || opc[3:0] == FORM_DIR ||
                     (is_acc_grp(opc) && opc[3:0] == FORM_IMM)) begin
            return 2'd2;
        end
        return 2'd1;
    endfunction

    // Instruction cycles
    function automatic logic [1:0] alx_cycles(input logic [7:0] opc);
        if (opc == OPC_REL_JUMP || (is_logic_dir(opc) && opc[3:0] == FORM_DIR_IMM)) begin
            return 2'd2;
        end
        return 2'd1;
    endfunction

    // Clock index of the last clock of an instruction
    function automatic logic [3:0] alx_last_clk(input logic [7:0] opc);
        logic [3:0] c;
        c = {2'b00, alx_cycles(opc)};
        return 4'(c * CYCLE_CLKS) - 4'h1;
    endfunction

endpackage

// ==== arith_logic_instruction_exec_tb.sv ====
// Self-checking bench for the arithmetic/logic execution core.
// Assumes a combinational code ROM on code_data; RAM is seeded by the programs themselves.
`timescale 1ns/1ps
`default_nettype none
module arith_logic_instruction_exec_tb;

    // Clock, reset and core ports
    logic        ref_clk;
    logic        rst;
    logic [15:0] code_addr;
    logic [7:0]  code_data;
    logic [7:0]  acc_value;
    logic        carry_flag;
    logic        aux_carry_flag;
    logic        overflow_flag;
    logic        instr_done;
    logic [7:0]  rom [0:255];
    int          n_mismatch;
    int          checked;

    alx_core dut (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .code_addr      (code_addr),
        .code_data      (code_data),
        .acc_value      (acc_value),
        .carry_flag     (carry_flag),
        .aux_carry_flag (aux_carry_flag),
        .overflow_flag  (overflow_flag),
        .instr_done     (instr_done)
    );

    // Code ROM answers in the same cycle, as the core expects
    assign code_data = rom[code_addr[7:0]];

    // 100 ns period
    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    task automatic tally_and_finish();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Value compare, case equality so unknowns never match
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Program bytes are given first byte in the top bits; the rest of ROM reads 00
    task automatic load_prog(input logic [511:0] p, input int n);
        for (int i = 0; i < 256; i++) begin
            rom[i] = (i < n) ? p[8*(n-1-i) +: 8] : 8'h00;
        end
    endtask

    // Reset for 6 cycles and check the values seen under reset
    task automatic do_reset();
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (6) @(negedge ref_clk);
        cmp(code_addr, 16'h0000);
        cmp({8'h00, acc_value}, 16'h0000);
        cmp({12'h000, carry_flag, aux_carry_flag, overflow_flag, instr_done}, 16'h0000);
        rst = 1'b0;
    endtask

    // Wait for the next completion; check spacing, next fetch address, acc and flags
    task automatic step(input int clks, input logic [15:0] addr, input logic [7:0] acc,
                        input logic [2:0] flg);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (instr_done !== 1'b1 && n < 20);
        if (instr_done !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, 16'(n), 16'(clks));
            tally_and_finish();
        end
        cmp(16'(n), 16'(clks));
        cmp(code_addr, addr);
        cmp({8'h00, acc_value}, {8'h00, acc});
        cmp({13'h0000, carry_flag, aux_carry_flag, overflow_flag}, {13'h0000, flg});
    endtask

    // Immediate add, add-with-carry and subtract-with-borrow with flag corners
    task automatic sc_arith_imm();
        load_prog(128'h24F0_2420_340F_2470_2480_2401_9412_940F, 16);
        do_reset();
        step(4, 16'h0002, 8'hF0, 3'h0);
        step(4, 16'h0004, 8'h10, 3'h4);
        step(4, 16'h0006, 8'h20, 3'h2);
        step(4, 16'h0008, 8'h90, 3'h1);
        step(4, 16'h000A, 8'h10, 3'h5);
        step(4, 16'h000C, 8'h11, 3'h0);
        step(4, 16'h000E, 8'hFF, 3'h6);
        step(4, 16'h0010, 8'hEF, 3'h2);
    endtask

    // Direct-byte logic, indirect pointers, register forms and direct/indirect subtract
    task automatic sc_memory_forms();
        load_prog({176'h5330_0043_305A_6330_FF25_3064_F052_3065_3053_0000_4300,
                   176'h3053_0100_4301_3153_3100_4331_0C06_4657_2895_3197_9839}, 44);
        do_reset();
        step(8, 16'h0003, 8'h00, 3'h0);
        step(8, 16'h0006, 8'h00, 3'h0);
        step(8, 16'h0009, 8'h00, 3'h0);
        step(4, 16'h000B, 8'hA5, 3'h0);
        step(4, 16'h000D, 8'h55, 3'h0);
        step(4, 16'h000F, 8'h55, 3'h0);
        step(4, 16'h0011, 8'h50, 3'h0);
        for (int i = 0; i < 6; i++) begin
            step(8, 16'(20 + 3 * i), 8'h50, 3'h0);
        end
        step(4, 16'h0024, 8'h50, 3'h0);
        step(4, 16'h0025, 8'h56, 3'h0);
        step(4, 16'h0026, 8'h04, 3'h0);
        step(4, 16'h0027, 8'h34, 3'h0);
        step(4, 16'h0029, 8'h28, 3'h2);
        step(4, 16'h002A, 8'h1C, 3'h2);
        step(4, 16'h002B, 8'hEC, 3'h4);
        step(4, 16'h002C, 8'h1E, 3'h4);
    endtask

    // Wrap of increment/decrement, flags kept, backward relative jump
    task automatic sc_wrap_and_jump();
        load_prog(72'h1424_0114_0444_0F80_FA, 9);
        do_reset();
        step(4, 16'h0001, 8'hFF, 3'h0);
        step(4, 16'h0003, 8'h00, 3'h6);
        step(4, 16'h0004, 8'hFF, 3'h6);
        step(4, 16'h0005, 8'h00, 3'h6);
        step(4, 16'h0007, 8'h0F, 3'h6);
        step(8, 16'h0003, 8'h0F, 3'h6);
        step(4, 16'h0004, 8'h0E, 3'h6);
        step(4, 16'h0005, 8'h0F, 3'h6);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        n_mismatch = 0;
        checked = 0;
        load_prog(512'h0, 0);
        repeat (6) @(negedge ref_clk);
        sc_arith_imm();
        sc_memory_forms();
        sc_wrap_and_jump();
        tally_and_finish();
    end

endmodule
`default_nettype wire
